/* verilog/tsc_pkg.sv */
// package of constants and types for the temperature sensor serial block
package tsc_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 10_000_000; // system clock rate
	localparam int CONV_PERIOD_MS = 500; // one conversion every 500 ms (2 Hz)
	localparam int CONV_CYC = CLK_HZ / 1000 * CONV_PERIOD_MS; // cycles per conversion
	localparam int TIMEOUT_MIN_MS = 25; // bus timeout window is 25 to 48 ms
	localparam int TIMEOUT_MAX_MS = 48; // upper end of the window
	localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MIN_MS; // least time, whole cycles
	localparam int TO_W = 18; // timeout counter width
	localparam int CONV_W = 23; // conversion divider width

	// ----------------------------------------
	// pointer values and register layout
	// ----------------------------------------
	localparam logic [2:0] PTR_TEMP = 3'h0; // temperature_reading
	localparam logic [2:0] PTR_CFG = 3'h1; // device_configuration
	localparam logic [2:0] PTR_THIGH = 3'h2; // upper limit
	localparam logic [2:0] PTR_TLOW = 3'h3; // lower limit
	localparam logic [2:0] PTR_HYST = 3'h4; // hysteresis_limit
	localparam logic HAS_LIMITS = 1'b1; // threshold variant built
	localparam int TEMP_LSB_POS = 3; // 13-bit value sits in [15:3]
	localparam int STAT_HI_POS = 1; // temperature above upper limit
	localparam int STAT_LO_POS = 0; // temperature below lower limit
	localparam int CFG_SHDN_POS = 0; // shutdown bit
	localparam int CFG_FQ_POS = 4; // fault queue enable bit
	localparam int CFG_TODIS_POS = 7; // bus timeout disable bit
	localparam logic [7:0] CFG_RST = 8'h00; // configuration after reset
	localparam logic [15:0] THIGH_RST = 16'h5000; // upper limit after reset
	localparam logic [15:0] TLOW_RST = 16'h0000; // lower limit after reset
	localparam logic [15:0] HYST_RST = 16'h4B00; // hysteresis after reset
	localparam logic [2:0] ADDR_UPPER = 3'h4; // fixed upper address bits, arbitrary value

	// ----------------------------------------
	// serial state machine, gray along the usual path except the ST_RACK to ST_IDLE exit
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_AACK = 3'h3,
		ST_WRX = 3'h2,
		ST_WACK = 3'h6,
		ST_RTX = 3'h7,
		ST_RACK = 3'h5
	} tsc_state_t;
endpackage

/* verilog/tsc_conv.sv */
// periodic conversion engine: samples the front end at the conversion rate
`timescale 1ns/10ps
module tsc_conv #(
	parameter int CONV_CYC = tsc_pkg::CONV_CYC
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic enable,
	input wire logic [12:0] die_temp,
	output logic [12:0] result,
	output logic done
);
	import tsc_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [12:0] s1; // first sync stage, read only by s2
		logic [12:0] s2; // second sync stage
		logic [CONV_W-1:0] div; // conversion rate divider
		logic [12:0] result; // latest conversion
		logic done; // one-cycle pulse per result
	} tsc_conv_t;
	tsc_conv_t c_r, c_nxt;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// front end word is held steady between samples, so a plain two-stage word
	// sync is safe here; a changing word would need a handshake instead
	always_comb begin
		c_nxt = c_r;
		c_nxt.s1 = die_temp;
		c_nxt.s2 = c_r.s1;
		c_nxt.done = 1'b0;
		if (enable) begin
			// divider stops in shutdown, so no conversion runs
			if (c_r.div == CONV_W'(CONV_CYC - 1)) begin
				c_nxt.div = '0;
				c_nxt.result = c_r.s2;
				c_nxt.done = 1'b1;
			end else begin
				c_nxt.div = c_r.div + 1'b1;
			end
		end
	end

	// register update
	always_ff @(posedge clock) begin
		if (reset) begin
			c_r <= '0;
		end else begin
			c_r <= c_nxt;
		end
	end

	assign result = c_r.result;
	assign done = c_r.done;
endmodule

/* verilog/tsc_top.sv */
// serial register interface of the die temperature sensor
`timescale 1ns/10ps
module tsc_top #(
	parameter int CONV_CYC = tsc_pkg::CONV_CYC,
	parameter int TIMEOUT_CYC = tsc_pkg::TIMEOUT_CYC
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_strap_bit0,
	input wire logic addr_strap_bit1,
	input wire logic addr_strap_bit2,
	input wire logic addr_strap_bit3,
	input wire logic [12:0] die_temp,
	output logic alert_out,
	output logic alert_oe,
	output logic overtemp_shutdown_output,
	output logic overtemp_oe
);
	import tsc_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] scl_sy; // [0] first stage, [1] second, [2] previous
		logic [2:0] sda_sy; // same layout as scl
		logic [3:0] strap1; // first strap stage
		logic [3:0] strap2; // synchronised straps
		tsc_state_t st; // serial state
		logic [3:0] bitcnt; // bits in current byte
		logic [7:0] sh; // shift register
		logic [1:0] bidx; // byte index in transfer
		logic rw; // 1 = read transfer
		logic [2:0] ptr; // pointer register
		logic [7:0] cfg; // device_configuration
		logic [15:0] temp; // temperature_reading
		logic [15:0] thigh; // upper limit
		logic [15:0] tlow; // lower limit
		logic [15:0] thyst; // hysteresis_limit
		logic [7:0] rxhi; // high byte waiting for low byte
		logic hi_pend; // fault queue: one high fault seen
		logic lo_pend; // fault queue: one low fault seen
		logic [TO_W-1:0] tocnt; // scl low time while busy
		logic sda_oe; // pulling sda low
		logic alert_oe; // pulling alarm low
		logic ovt_oe; // pulling overtemp low
	} tsc_top_t;
	tsc_top_t s_r, s_nxt;

	logic [12:0] conv_val; // conversion result
	logic conv_done; // new result pulse

	// ----------------------------------------
	// conversion engine
	// ----------------------------------------
	tsc_conv #(.CONV_CYC(CONV_CYC)) u_conv (
		.clock(clock),
		.reset(reset),
		.enable(!s_r.cfg[CFG_SHDN_POS]),
		.die_temp(die_temp),
		.result(conv_val),
		.done(conv_done)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// byte of the selected register, high byte at index 0
	function automatic logic [7:0] get_byte(input tsc_top_t s, input logic idx);
		logic [15:0] w;
		w = 16'h0000;
		unique case (s.ptr)
			PTR_TEMP: w = s.temp;
			PTR_CFG: w = {s.cfg, s.cfg}; // 8-bit register repeats
			PTR_THIGH: w = HAS_LIMITS ? s.thigh : 16'h0000;
			PTR_TLOW: w = HAS_LIMITS ? s.tlow : 16'h0000;
			PTR_HYST: w = HAS_LIMITS ? s.thyst : 16'h0000;
			default: w = 16'h0000; // unmapped pointer reads zero
		endcase
		get_byte = idx ? w[7:0] : w[15:8];
	endfunction

	// signed compare of two 13-bit temperature fields
	function automatic logic t_gt(input logic [15:0] a, input logic [15:0] b);
		t_gt = $signed(a[15:TEMP_LSB_POS]) > $signed(b[15:TEMP_LSB_POS]);
	endfunction

	// bus events from the synchronised pins; stage 0 is never read here
	wire scl_hi = s_r.scl_sy[1];
	wire scl_rise = s_r.scl_sy[1] & ~s_r.scl_sy[2];
	wire scl_fall = ~s_r.scl_sy[1] & s_r.scl_sy[2];
	wire bus_start = scl_hi & s_r.scl_sy[2] & s_r.sda_sy[2] & ~s_r.sda_sy[1];
	wire bus_stop = scl_hi & s_r.scl_sy[2] & ~s_r.sda_sy[2] & s_r.sda_sy[1];
	wire [6:0] my_addr = {ADDR_UPPER, s_r.strap2};
	wire to_hit = (s_r.tocnt == TO_W'(TIMEOUT_CYC)) & ~s_r.cfg[CFG_TODIS_POS];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [7:0] b;
		logic [15:0] t;
		b = 8'h00;
		t = 16'h0000;
		s_nxt = s_r;
		// two flip-flops on every pin before any logic
		s_nxt.scl_sy = {s_r.scl_sy[1], s_r.scl_sy[0], scl_in};
		s_nxt.sda_sy = {s_r.sda_sy[1], s_r.sda_sy[0], sda_in};
		s_nxt.strap1 = {addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
		s_nxt.strap2 = s_r.strap1;

		// conversion result and alarm flags
		if (conv_done) begin
			t = {conv_val, 3'h0};
			if (HAS_LIMITS) begin
				// limit variant: status in [1:0], bit two stays zero
				t[STAT_HI_POS] = t_gt(t, s_r.thigh);
				t[STAT_LO_POS] = t_gt(s_r.tlow, t);
				// fault queue wants two faults in a row before alarming
				s_nxt.hi_pend = t[STAT_HI_POS];
				s_nxt.lo_pend = t[STAT_LO_POS];
				if (s_r.cfg[CFG_FQ_POS]) begin
					s_nxt.alert_oe = (t[STAT_HI_POS] & s_r.hi_pend) |
						(t[STAT_LO_POS] & s_r.lo_pend);
				end else begin
					s_nxt.alert_oe = t[STAT_HI_POS] | t[STAT_LO_POS];
				end
				// overtemp sets above upper limit, clears below hysteresis
				if (t_gt(t, s_r.thigh)) begin
					s_nxt.ovt_oe = 1'b1;
				end else if (t_gt(s_r.thyst, t)) begin
					s_nxt.ovt_oe = 1'b0;
				end
			end
			s_nxt.temp = t; // low three bits zero without limits
		end

		// timeout counts scl low time inside a transfer
		if (s_r.st != ST_IDLE && !scl_hi) begin
			s_nxt.tocnt = to_hit ? s_r.tocnt : s_r.tocnt + 1'b1;
		end else begin
			s_nxt.tocnt = '0;
		end

		// serial slave
		if (bus_start) begin
			s_nxt.st = ST_ADDR;
			s_nxt.bitcnt = 4'h0;
			s_nxt.bidx = 2'h0; // pointer itself is kept
			s_nxt.sda_oe = 1'b0;
		end else if (bus_stop || to_hit) begin
			// stop or stalled transfer ends it, sda released
			s_nxt.st = ST_IDLE;
			s_nxt.sda_oe = 1'b0;
		end else begin
			unique case (s_r.st)
				ST_IDLE: begin
					s_nxt.sda_oe = 1'b0;
				end
				ST_ADDR, ST_WRX: begin
					// data sampled on scl rise
					if (scl_rise) begin
						s_nxt.sh = {s_r.sh[6:0], s_r.sda_sy[1]};
						s_nxt.bitcnt = s_r.bitcnt + 1'b1;
					end else if (scl_fall && s_r.bitcnt == 4'h8) begin
						if (s_r.st == ST_ADDR) begin
							if (s_r.sh[7:1] == my_addr) begin
								s_nxt.st = ST_AACK;
								s_nxt.rw = s_r.sh[0];
								s_nxt.sda_oe = 1'b1;
							end else begin
								s_nxt.st = ST_IDLE; // other device
							end
						end else begin
							s_nxt.st = ST_WACK;
							s_nxt.sda_oe = 1'b1;
							if (s_r.bidx == 2'h0) begin
								s_nxt.ptr = s_r.sh[2:0];
							end else if (s_r.ptr == PTR_CFG && s_r.bidx == 2'h1) begin
								s_nxt.cfg = s_r.sh;
							end else if (s_r.bidx == 2'h1) begin
								s_nxt.rxhi = s_r.sh; // high byte first
							end else if (HAS_LIMITS && s_r.bidx == 2'h2) begin
								// temperature register ignores writes
								if (s_r.ptr == PTR_THIGH) s_nxt.thigh = {s_r.rxhi, s_r.sh};
								if (s_r.ptr == PTR_TLOW) s_nxt.tlow = {s_r.rxhi, s_r.sh};
								if (s_r.ptr == PTR_HYST) s_nxt.thyst = {s_r.rxhi, s_r.sh};
							end
							if (s_r.bidx != 2'h3) s_nxt.bidx = s_r.bidx + 1'b1;
						end
					end
				end
				ST_AACK, ST_RACK: begin
					// host not acking a read byte ends our part
					if (scl_rise && s_r.st == ST_RACK && s_r.sda_sy[1]) begin
						s_nxt.st = ST_IDLE;
					end else if (scl_fall) begin
						if (s_r.rw) begin
							b = get_byte(s_r, s_r.bidx[0]);
							s_nxt.sh = b;
							s_nxt.sda_oe = ~b[7];
							s_nxt.bitcnt = 4'h1;
							s_nxt.bidx = {1'b0, ~s_r.bidx[0]};
							s_nxt.st = ST_RTX;
						end else begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.bitcnt = 4'h0;
							s_nxt.st = ST_WRX;
						end
					end
				end
				ST_WACK: begin
					if (scl_fall) begin
						s_nxt.sda_oe = 1'b0;
						s_nxt.bitcnt = 4'h0;
						s_nxt.st = ST_WRX;
					end
				end
				ST_RTX: begin
					// next bit out after scl falls
					if (scl_fall) begin
						if (s_r.bitcnt == 4'h8) begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.st = ST_RACK;
						end else begin
							s_nxt.sh = {s_r.sh[6:0], 1'b0};
							s_nxt.sda_oe = ~s_r.sh[6];
							s_nxt.bitcnt = s_r.bitcnt + 1'b1;
						end
					end
				end
				default: begin
					s_nxt.st = ST_IDLE; // unused code
					s_nxt.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// register update
	always_ff @(posedge clock) begin
		if (reset) begin
			s_r <= '0;
			s_r.scl_sy <= 3'h7;
			s_r.sda_sy <= 3'h7;
			s_r.st <= ST_IDLE;
			s_r.ptr <= PTR_TEMP;
			s_r.cfg <= CFG_RST;
			s_r.thigh <= THIGH_RST;
			s_r.tlow <= TLOW_RST;
			s_r.thyst <= HYST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// outputs: open drain, level always low
	// ----------------------------------------
	assign sda_out = 1'b0 & s_r.sda_oe;
	assign sda_oe = s_r.sda_oe;
	assign alert_out = 1'b0 & s_r.alert_oe;
	assign alert_oe = s_r.alert_oe;
	assign overtemp_shutdown_output = 1'b0 & s_r.ovt_oe;
	assign overtemp_oe = s_r.ovt_oe;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	addr_ack_a: assert property (@(posedge clock) disable iff (reset)
		s_r.st == ST_ADDR && scl_fall && s_r.bitcnt == 4'h8 && !bus_start && !bus_stop &&
		!to_hit && s_r.sh[7:1] == my_addr |=> sda_oe && s_r.st == ST_AACK)
		else $error("own address not acknowledged");
	addr_other_a: assert property (@(posedge clock) disable iff (reset)
		s_r.st == ST_ADDR && s_r.sh[7:1] != my_addr && scl_fall && s_r.bitcnt == 4'h8
		|=> !sda_oe)
		else $error("foreign address acknowledged");
	temp_load_a: assert property (@(posedge clock) disable iff (reset)
		conv_done |=> s_r.temp[15:3] == $past(conv_val))
		else $error("temperature not updated");
	temp_ro_a: assert property (@(posedge clock) disable iff (reset)
		$changed(s_r.temp) |-> $past(conv_done))
		else $error("temperature changed without conversion");
	bit_two_a: assert property (@(posedge clock) disable iff (reset)
		s_r.temp[2] == 1'b0)
		else $error("unused bit two set");
	shdn_stop_a: assert property (@(posedge clock) disable iff (reset)
		s_r.cfg[CFG_SHDN_POS] && $past(s_r.cfg[CFG_SHDN_POS]) |-> !conv_done)
		else $error("conversion during shutdown");
	ptr_write_a: assert property (@(posedge clock) disable iff (reset)
		s_r.st == ST_WRX && scl_fall && s_r.bitcnt == 4'h8 && s_r.bidx == 2'h0 &&
		!bus_start && !bus_stop && !to_hit |=> s_r.ptr == $past(s_r.sh[2:0]))
		else $error("pointer byte not stored");
	ptr_keep_a: assert property (@(posedge clock) disable iff (reset)
		bus_start |=> $stable(s_r.ptr))
		else $error("pointer lost at start");
	bus_timeout_a: assert property (@(posedge clock) disable iff (reset)
		to_hit && !bus_start |=> s_r.st == ST_IDLE && !sda_oe)
		else $error("timeout did not release bus");
endmodule

/* sim/tsc_host_model.sv */
// bus master model that drives the two-wire serial pins of the sensor
`timescale 1ns/10ps
module tsc_host_model (
	input wire logic clock,
	input wire logic sda_line,
	output logic scl,
	output logic sda_pull
);
	// ----------------------------------------
	// pin timing: 800 ns bit period, scl high between frames
	// ----------------------------------------
	initial begin
		scl = 1'b1; // bus idles released
		sda_pull = 1'b0;
	end

	// moves always land just after a rising edge
	task wait_n(input int n);
		repeat (n) @(posedge clock);
		#10;
	endtask

	// one bit: data changes mid low phase, sampled at end of high phase
	task bit_xfer(input logic b, output logic s);
		wait_n(2);
		sda_pull = ~b; // open drain: only ever pull low
		wait_n(2);
		scl = 1'b1;
		wait_n(4);
		s = sda_line;
		scl = 1'b0;
	endtask

	// start or repeated start: sda falls while scl high
	task start;
		sda_pull = 1'b0;
		wait_n(2);
		scl = 1'b1;
		wait_n(4);
		sda_pull = 1'b1;
		wait_n(4);
		scl = 1'b0;
	endtask

	// stop: sda rises while scl high, then scl stays high
	task stop;
		wait_n(2);
		sda_pull = 1'b1;
		wait_n(2);
		scl = 1'b1;
		wait_n(4);
		sda_pull = 1'b0;
		wait_n(4);
	endtask

	// byte out msb first, ack is the device pulling the ninth bit low
	task send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], s);
		end
		bit_xfer(1'b1, s);
		ack = ~s;
	endtask

	// byte in, host acks all but the last byte
	task recv_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, d[i]);
		end
		bit_xfer(~ack, s);
	endtask

	// write: pointer byte first, then zero, one or two data bytes
	task wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d, input int n,
		output logic ok);
		logic k;
		start;
		send_byte({a, 1'b0}, ok);
		send_byte(p, k);
		ok &= k;
		if (n == 2) begin
			send_byte(d[15:8], k); // high byte first on word writes
			ok &= k;
		end
		if (n >= 1) begin
			send_byte(d[7:0], k);
			ok &= k;
		end
		stop;
	endtask

	// read: optional pointer set, repeated start, n bytes, last one nacked
	task rd(input logic [6:0] a, input logic setp, input logic [7:0] p, input int n,
		output logic [15:0] d, output logic ok);
		logic k;
		logic [7:0] b;
		ok = 1'b1;
		d = 16'h0000;
		if (setp) begin
			start;
			send_byte({a, 1'b0}, k);
			ok &= k;
			send_byte(p, k);
			ok &= k;
		end
		start;
		send_byte({a, 1'b1}, k);
		ok &= k;
		for (int i = 0; i < n; i++) begin
			recv_byte(i < n - 1, b);
			d = {d[7:0], b};
		end
		stop;
	endtask
endmodule

/* sim/tb_top.sv */
// self-checking bench for the sensor serial register block
`timescale 1ns/10ps
module tb_top;
	import tsc_pkg::*;
	localparam int CONV = 200; // shortened conversion period
	localparam int TOUT = 300; // shortened bus timeout
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [3:0] strap = 4'hA; // strap pins, low address bits
	logic [12:0] die_temp = 13'h0190; // +25.0 degrees
	logic sda_out;
	logic sda_oe;
	logic alert_out;
	logic alert_oe;
	logic ot_out;
	logic ot_oe;
	logic scl;
	logic host_pull;
	wire sda_line;
	int err_total = 0;
	int samples_checked = 0;
	logic [15:0] rd_v;
	logic ok;
	logic [6:0] me;
	logic [15:0] lim_rst [3];

	// pulled-up wire, low if either side pulls
	assign sda_line = ~(host_pull | (sda_oe & ~sda_out));

	always #50 clock = ~clock;

	tsc_top #(.CONV_CYC(CONV), .TIMEOUT_CYC(TOUT)) dut (
		.clock(clock),
		.reset(reset),
		.scl_in(scl),
		.sda_in(sda_line),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.addr_strap_bit0(strap[0]),
		.addr_strap_bit1(strap[1]),
		.addr_strap_bit2(strap[2]),
		.addr_strap_bit3(strap[3]),
		.die_temp(die_temp),
		.alert_out(alert_out),
		.alert_oe(alert_oe),
		.overtemp_shutdown_output(ot_out),
		.overtemp_oe(ot_oe)
	);

	tsc_host_model host (
		.clock(clock),
		.sda_line(sda_line),
		.scl(scl),
		.sda_pull(host_pull)
	);

	// ----------------------------------------
	// report and compare helpers
	// ----------------------------------------
	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask

	task chk_bit(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			$display("unexpected %s: expected %b seen %b", what, exp, got);
			err_total++;
		end
	endtask

	// expected register image: value on top, bit two zero, two status flags
	function automatic logic [15:0] tv(input logic [12:0] t, input logic hi, input logic lo);
		return {t, 1'b0, hi, lo};
	endfunction

	// word read of one pointer, acked and compared
	task rd_word(input string what, input logic [7:0] p, input logic [15:0] exp);
		host.rd(me, 1'b1, p, 2, rd_v, ok);
		chk_bit("read ack", 1'b1, ok);
		chk_val(what, exp, rd_v);
	endtask

	// one conversion period plus margin; pipeline is a few clocks
	task conv_wait;
		host.wait_n(CONV + 60);
	endtask

	// hang guard: the whole run fits well inside this
	initial begin
		repeat (100000) @(posedge clock);
		err_total++;
		end_sim;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		lim_rst = '{THIGH_RST, TLOW_RST, HYST_RST};
		repeat (16) @(posedge clock);
		#10;
		reset = 1'b0;
		host.wait_n(4); // sync pipeline settles before first start
		me = {ADDR_UPPER, strap};
		host.rd(me, 1'b1, 8'h01, 1, rd_v, ok);
		chk_val("config after reset", 16'h0000, rd_v);
		for (int i = 0; i < 3; i++) begin
			rd_word("limit after reset", 8'(i + 2), lim_rst[i]);
		end
		conv_wait;
		rd_word("temperature", 8'h00, tv(13'h0190, 1'b0, 1'b0));
		chk_bit("alarm idle", 1'b0, alert_oe);
		chk_bit("overtemp idle", 1'b0, ot_oe);
		host.rd(me, 1'b0, 8'h00, 2, rd_v, ok);
		chk_val("read with kept pointer", tv(13'h0190, 1'b0, 1'b0), rd_v);
		// stall with the device holding a zero data bit
		host.start;
		host.send_byte({me, 1'b1}, ok);
		host.wait_n(10);
		chk_bit("read data drive", 1'b1, sda_oe);
		host.wait_n(TOUT + 20);
		chk_bit("released after stall", 1'b0, sda_oe);
		host.stop;
		// new strap setting moves the address, old one no longer answers
		strap = 4'h5;
		host.wait_n(6);
		host.wr(me, 8'h01, 16'h0000, 0, ok);
		chk_bit("old address ack", 1'b0, ok);
		me = {ADDR_UPPER, strap};
		host.rd(me, 1'b1, 8'h01, 1, rd_v, ok);
		chk_bit("new address ack", 1'b1, ok);
		// read-only temperature ignores a word write
		host.wr(me, 8'h00, 16'h1234, 2, ok);
		rd_word("temperature after write", 8'h00, tv(13'h0190, 1'b0, 1'b0));
		die_temp = 13'h1FF0; // -1.0 degree, below lower limit
		conv_wait;
		rd_word("negative temperature", 8'h00, tv(13'h1FF0, 1'b0, 1'b1));
		chk_bit("alarm low", 1'b1, alert_oe);
		// shutdown freezes the reading but the bus still works
		host.wr(me, 8'h01, 16'h0001, 1, ok);
		die_temp = 13'h0190;
		conv_wait;
		rd_word("frozen temperature", 8'h00, tv(13'h1FF0, 1'b0, 1'b1));
		host.rd(me, 1'b1, 8'h01, 1, rd_v, ok);
		chk_val("config readback", 16'h0001, rd_v);
		host.wr(me, 8'h01, 16'h0000, 1, ok);
		conv_wait;
		rd_word("temperature resumed", 8'h00, tv(13'h0190, 1'b0, 1'b0));
		// fault queue: one low reading must not alarm, two in a row must
		// first low result lands no earlier than edge 4, the second no earlier than 204
		host.wr(me, 8'h01, 16'h0010, 1, ok);
		die_temp = 13'h1FF0;
		host.wait_n(CONV);
		chk_bit("alarm after one fault", 1'b0, alert_oe);
		host.wait_n(CONV + 20);
		chk_bit("alarm after two faults", 1'b1, alert_oe);
		chk_bit("alarm pin level", 1'b0, alert_out);
		die_temp = 13'h0190;
		conv_wait;
		chk_bit("alarm cleared", 1'b0, alert_oe);
		// timeout disabled: a stall is held until the host clocks on
		host.wr(me, 8'h01, 16'h0080, 1, ok);
		host.wr(me, 8'h00, 16'h0000, 0, ok);
		host.start;
		host.send_byte({me, 1'b1}, ok);
		host.wait_n(TOUT + 20);
		chk_bit("held without timeout", 1'b1, sda_oe);
		// clock the held byte out, nack it, then the bus can stop again
		host.recv_byte(1'b0, rd_v[7:0]);
		host.stop;
		chk_val("byte after stall", 16'h000C, {8'h00, rd_v[7:0]});
		host.wr(me, 8'h01, 16'h0000, 1, ok);
		chk_bit("config write ack", 1'b1, ok);
		// overtemp: upper below reading, hysteresis at zero
		host.wr(me, 8'h04, 16'h0000, 2, ok);
		host.wr(me, 8'h02, 16'h0800, 2, ok);
		rd_word("upper limit", 8'h02, 16'h0800);
		conv_wait;
		rd_word("temperature high", 8'h00, tv(13'h0190, 1'b1, 1'b0));
		chk_bit("overtemp set", 1'b1, ot_oe);
		chk_bit("overtemp pin level", 1'b0, ot_out);
		die_temp = 13'h1FF0;
		conv_wait;
		chk_bit("overtemp cleared", 1'b0, ot_oe);
		end_sim;
	end
endmodule
